// File: design/scss_clock_select.sv
// system clock source selection, glitch-free switch, pll and pin sharing
module scss_clock_select
  import scss_pkg::*;
(
  input  wire logic       ref_clk,                     // 100 MHz block clock
  input  wire logic       resetn,                      // async reset, active low
  input  wire logic       osc_input_pin_i,             // input pin level
  output logic            osc_input_pin_o,             // input pin drive as port bit seven
  output logic            osc_input_pin_oe_n,          // input pin drive enable, low drives
  input  wire logic       osc_output_pin_i,            // output pin level
  output logic            osc_output_pin_o,            // output pin drive
  output logic            osc_output_pin_oe_n,         // output pin drive enable, low drives
  input  wire logic       fast_rc_osc,                 // fast rc oscillator, 8 MHz
  input  wire logic       slow_rc_osc,                 // slow rc oscillator, 31 kHz
  input  wire logic       timer_osc,                   // timer oscillator
  input  wire logic       config_loaded,               // configuration values valid
  input  wire logic [2:0] osc_config,                  // oscillator configuration bits
  input  wire logic       ctrl_wr,                     // control write strobe
  input  wire logic [1:0] clock_source_select_wr,      // written select field
  input  wire logic [2:0] internal_freq_select_wr,     // written frequency select
  input  wire logic       pll_enable_bit_wr,           // written pll enable
  input  wire logic       low_freq_source_select_wr,   // written low-frequency source
  input  wire logic       pwrt_en,                     // power-up timer enabled
  input  wire logic       fscm_en,                     // fail-safe clock monitor enabled
  input  wire logic       wdt_en,                      // watchdog enabled
  input  wire logic       two_speed_en,                // two-speed start-up enabled
  input  wire logic       port_bit_seven_out,          // port bit seven data
  input  wire logic       port_bit_seven_dir_n,        // port bit seven drive, low drives
  input  wire logic       port_bit_six_out,            // port bit six data
  input  wire logic       port_bit_six_dir_n,          // port bit six drive, low drives
  output logic            port_bit_seven_in,           // port bit seven read value
  output logic            port_bit_six_in,             // port bit six read value
  output logic [1:0]      clock_source_select,         // select field read-back
  output logic [2:0]      internal_freq_select,        // frequency select read-back
  output logic            pll_enable_bit,              // pll enable read-back
  output logic            low_freq_source_select,      // low-frequency source read-back
  output logic            sys_clk_en,                  // device clock pulse
  output logic [1:0]      active_src,                  // source driving device clock
  output logic            switching,                   // switch in progress
  output logic            osc_ready,                   // primary oscillator ready
  output logic            pll_active,                  // pll multiplying
  output logic            fast_rc_en,                  // fast rc oscillator enable
  output logic            slow_rc_en,                  // slow rc oscillator enable
  output logic            feedback_en                  // crystal feedback enable
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [N_SYNC-1:0] sy1_reg;
  logic [N_SYNC-1:0] sy2_reg;
  logic [N_SYNC-1:0] sy3_reg;
  logic [N_SYNC-1:0] rise;

  // oscillators are asynchronous to ref_clk; edges seen only after stage two
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sy1_reg <= '0;
      sy2_reg <= '0;
      sy3_reg <= '0;
    end else begin
      sy1_reg <= {osc_output_pin_i, timer_osc, slow_rc_osc, fast_rc_osc, osc_input_pin_i};
      sy2_reg <= sy1_reg;
      sy3_reg <= sy2_reg;
    end
  end

  assign rise = sy2_reg & ~sy3_reg;

  // ****************************************************************
  // configuration capture and mode decode
  // ****************************************************************
  logic [2:0] cfg_reg;
  logic       cfg_valid_reg;
  logic       is_ec, is_hs, is_int, is_ext_pll, is_int_pll, mode_one, mode_two;

  // strap caught by the clock after release, never by the reset itself
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_reg       <= CFG_INT_IO_TWO;
      cfg_valid_reg <= 1'b0;
    end else if (config_loaded && !cfg_valid_reg) begin
      cfg_reg       <= osc_config;
      cfg_valid_reg <= 1'b1;
    end
  end

  assign is_ec      = cfg_valid_reg && (cfg_reg == CFG_EXT_CLK || cfg_reg == CFG_EXT_CLK_PLL);
  assign is_hs      = cfg_valid_reg && (cfg_reg == CFG_CRYSTAL || cfg_reg == CFG_CRYSTAL_PLL);
  assign is_ext_pll = cfg_valid_reg && (cfg_reg == CFG_EXT_CLK_PLL || cfg_reg == CFG_CRYSTAL_PLL);
  assign is_int_pll = cfg_valid_reg && (cfg_reg == CFG_INT_PLL_ONE || cfg_reg == CFG_INT_PLL_TWO);
  assign is_int     = cfg_valid_reg && !is_ec && !is_hs;
  assign mode_one   = cfg_valid_reg && (cfg_reg == CFG_INT_IO_ONE || cfg_reg == CFG_INT_PLL_ONE);
  assign mode_two   = cfg_valid_reg && (cfg_reg == CFG_INT_IO_TWO || cfg_reg == CFG_INT_PLL_TWO);

  // ****************************************************************
  // software control bits
  // ****************************************************************
  logic [1:0] css_reg;
  logic [2:0] ifs_reg;
  logic       pll_en_reg;
  logic       lfs_reg;

  // every reset returns to the configuration-defined primary at 4 MHz
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      css_reg    <= CSS_RESET;
      ifs_reg    <= IFS_RESET;
      pll_en_reg <= 1'b0;
      lfs_reg    <= 1'b0;
    end else if (ctrl_wr) begin
      css_reg    <= clock_source_select_wr;
      ifs_reg    <= internal_freq_select_wr;
      pll_en_reg <= pll_enable_bit_wr;
      lfs_reg    <= low_freq_source_select_wr;
    end
  end

  assign clock_source_select    = css_reg;
  assign internal_freq_select   = ifs_reg;
  assign pll_enable_bit         = pll_en_reg;
  assign low_freq_source_select = lfs_reg;

  // ****************************************************************
  // fast rc postscaler
  // ****************************************************************
  logic [7:0] ps_cnt_reg;
  logic [3:0] ps_shift;
  logic [8:0] ps_mask;
  logic       ps_tick, int_base_tick;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ps_cnt_reg <= '0;
    end else if (rise[SY_FAST]) begin
      ps_cnt_reg <= ps_cnt_reg + 8'h1;
    end
  end

  // divide by 2^(7-code); code 000 divides by 256
  assign ps_shift = (ifs_reg == IFS_31K) ? LF_SHIFT : {1'b0, IFS_8M - ifs_reg};
  assign ps_mask  = (9'h1 << ps_shift) - 9'h1;
  assign ps_tick  = rise[SY_FAST] && ((ps_cnt_reg & ps_mask[7:0]) == ps_mask[7:0]);
  // at 31 kHz the low-frequency source select picks divider or slow rc
  assign int_base_tick = (ifs_reg == IFS_31K && !lfs_reg) ? rise[SY_SLOW] : ps_tick;

  // ****************************************************************
  // four-times pll
  // ****************************************************************
  logic [PER_W-1:0] per_cnt_reg;
  logic [PER_W-1:0] per_reg;
  logic [PER_W-1:0] phase_reg;
  logic [PER_W-1:0] quarter;
  logic             pll_src_tick, pll_tick_reg, ext_pll_on, int_pll_on;
  logic [1:0]       pll_cnt_reg;

  // external pll needs the right configuration and the enable bit
  assign ext_pll_on = is_ext_pll && pll_en_reg;
  // internal pll only in its two configurations and at 8 or 4 MHz
  assign int_pll_on = is_int_pll && pll_en_reg &&
                      (ifs_reg == IFS_8M || ifs_reg == IFS_4M);
  assign pll_active   = ext_pll_on || int_pll_on;
  assign pll_src_tick = is_int ? int_base_tick : rise[SY_OSC_IN];
  assign quarter      = (per_reg >> PLL_SHIFT) == '0 ? {{(PER_W-1){1'b0}}, 1'b1}
                                                     : (per_reg >> PLL_SHIFT);

  // measure reference period, then emit four pulses in it; the cap stops a
  // truncated quarter from squeezing a fifth pulse into the period
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      per_cnt_reg  <= '0;
      per_reg      <= '0;
      phase_reg    <= '0;
      pll_tick_reg <= 1'b0;
      pll_cnt_reg  <= '0;
    end else if (pll_src_tick) begin
      per_reg      <= per_cnt_reg + {{(PER_W-1){1'b0}}, 1'b1};
      per_cnt_reg  <= '0;
      phase_reg    <= '0;
      pll_tick_reg <= 1'b1;
      pll_cnt_reg  <= '0;
    end else begin
      if (per_cnt_reg != '1) begin
        per_cnt_reg <= per_cnt_reg + {{(PER_W-1){1'b0}}, 1'b1};
      end
      pll_tick_reg <= (phase_reg == quarter - {{(PER_W-1){1'b0}}, 1'b1}) &&
                      (pll_cnt_reg != '1);
      if ((phase_reg == quarter - {{(PER_W-1){1'b0}}, 1'b1}) && (pll_cnt_reg != '1)) begin
        pll_cnt_reg <= pll_cnt_reg + 2'h1;
      end
      phase_reg    <= (phase_reg == quarter - {{(PER_W-1){1'b0}}, 1'b1}) ? '0
                      : phase_reg + {{(PER_W-1){1'b0}}, 1'b1};
    end
  end

  // ****************************************************************
  // crystal start-up and primary readiness
  // ****************************************************************
  logic [9:0] ost_cnt_reg;
  logic       ost_done_reg;
  logic       int_blk_tick, prim_tick;

  // only crystal modes wait for start-up; external clocks are ready at once
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ost_cnt_reg  <= '0;
      ost_done_reg <= 1'b0;
    end else if (is_hs && !ost_done_reg && rise[SY_OSC_IN]) begin
      ost_cnt_reg  <= ost_cnt_reg + 10'h1;
      ost_done_reg <= (ost_cnt_reg == OST_TICKS);
    end
  end

  assign osc_ready    = is_ec || is_int || ost_done_reg;
  assign int_blk_tick = int_pll_on ? pll_tick_reg : int_base_tick;
  assign prim_tick    = !osc_ready ? 1'b0 :
                        is_int     ? int_blk_tick :
                        ext_pll_on ? pll_tick_reg : rise[SY_OSC_IN];

  // ****************************************************************
  // requested source and glitch-free switch
  // ****************************************************************
  scss_src_t      req_src, cur_src_reg, new_src_reg;
  scss_sw_state_t st_reg;
  logic [1:0]     sw_cnt_reg;
  logic [3:0]     src_ticks;

  assign src_ticks[SRC_SLOW]  = rise[SY_SLOW];
  assign src_ticks[SRC_PRIM]  = prim_tick;
  assign src_ticks[SRC_TIMER] = rise[SY_TIMER];
  assign src_ticks[SRC_INTB]  = int_blk_tick;

  // select decode; primary owns two codes (00 and 10), timer and internal one each
  always_comb begin
    if (!cfg_valid_reg) begin
      req_src = SRC_SLOW;
    end else begin
      case (css_reg)
        CSS_TIMER:    req_src = SRC_TIMER;
        CSS_INTERNAL: req_src = SRC_INTB;
        default:      req_src = SRC_PRIM;
      endcase
    end
  end

  // old source finishes two cycles, new must give three before it runs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg      <= ST_RUN;
      cur_src_reg <= SRC_SLOW;
      new_src_reg <= SRC_SLOW;
      sw_cnt_reg  <= '0;
    end else begin
      case (st_reg)
        ST_RUN: begin
          if (req_src != cur_src_reg) begin
            st_reg      <= ST_OLD;
            new_src_reg <= req_src;
            sw_cnt_reg  <= '0;
          end
        end
        ST_OLD: begin
          if (src_ticks[cur_src_reg]) begin
            if (sw_cnt_reg == OLD_TICKS - 2'h1) begin
              st_reg     <= ST_NEW;
              sw_cnt_reg <= '0;
            end else begin
              sw_cnt_reg <= sw_cnt_reg + 2'h1;
            end
          end
        end
        ST_NEW: begin
          if (src_ticks[new_src_reg]) begin
            if (sw_cnt_reg == NEW_TICKS - 2'h1) begin
              st_reg      <= ST_RUN;
              cur_src_reg <= new_src_reg;
            end else begin
              sw_cnt_reg <= sw_cnt_reg + 2'h1;
            end
          end
        end
        default: st_reg <= ST_RUN;
      endcase
    end
  end

  assign active_src = cur_src_reg;
  assign switching  = (st_reg != ST_RUN);

  // ****************************************************************
  // device clock pulse and clock/4
  // ****************************************************************
  logic       sys_en_reg;
  logic [1:0] div_reg;

  // clock held quiet from the cycle after a switch starts until the cycle after it ends
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sys_en_reg <= 1'b0;
      div_reg    <= '0;
    end else begin
      sys_en_reg <= (st_reg == ST_RUN) && src_ticks[cur_src_reg];
      if (sys_en_reg) begin
        div_reg <= div_reg + 2'h1;
      end
    end
  end

  assign sys_clk_en = sys_en_reg;

  // ****************************************************************
  // pin sharing and oscillator enables
  // ****************************************************************
  logic out_reg, out_oe_n_reg, in_reg, in_oe_n_reg, fb_reg, fast_reg, slow_reg, intb_use;

  assign intb_use = cfg_valid_reg &&
                    (cur_src_reg == SRC_INTB || new_src_reg == SRC_INTB ||
                     (is_int && (cur_src_reg == SRC_PRIM || new_src_reg == SRC_PRIM)));

  // crystal modes leave both pins to the resonator and keep feedback on
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      out_reg      <= 1'b0;
      out_oe_n_reg <= 1'b1;
      in_reg       <= 1'b0;
      in_oe_n_reg  <= 1'b1;
      fb_reg       <= 1'b0;
      fast_reg     <= 1'b0;
      slow_reg     <= 1'b1;
    end else begin
      if (is_ec || mode_one) begin
        out_reg      <= div_reg[1];
        out_oe_n_reg <= 1'b0;
      end else if (mode_two) begin
        out_reg      <= port_bit_six_out;
        out_oe_n_reg <= port_bit_six_dir_n;
      end else begin
        out_reg      <= 1'b0;
        out_oe_n_reg <= 1'b1;
      end
      in_reg      <= port_bit_seven_out;
      in_oe_n_reg <= is_int ? port_bit_seven_dir_n : 1'b1;
      fb_reg      <= is_hs;
      fast_reg    <= intb_use && (ifs_reg != IFS_31K || lfs_reg);
      slow_reg    <= !cfg_valid_reg || cur_src_reg == SRC_SLOW ||
                     (intb_use && ifs_reg == IFS_31K && !lfs_reg) ||
                     pwrt_en || fscm_en || wdt_en || two_speed_en;
    end
  end

  assign osc_output_pin_o    = out_reg;
  assign osc_output_pin_oe_n = out_oe_n_reg;
  assign osc_input_pin_o     = in_reg;
  assign osc_input_pin_oe_n  = in_oe_n_reg;
  assign port_bit_seven_in   = sy2_reg[SY_OSC_IN];
  assign port_bit_six_in     = sy2_reg[SY_OSC_OUT];
  assign feedback_en         = fb_reg;
  assign fast_rc_en          = fast_reg;
  assign slow_rc_en          = slow_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_reset_select: assert property (@(posedge ref_clk) disable iff (!resetn)
    !$past(resetn) |-> css_reg == CSS_CONFIG && ifs_reg == IFS_4M)
    else $error("select fields not at reset value");
  a_slow_before_cfg: assert property (@(posedge ref_clk) disable iff (!resetn)
    !cfg_valid_reg |-> cur_src_reg == SRC_SLOW ##1 slow_rc_en)
    else $error("slow rc not clocking before configuration");
  a_two_codes: assert property (@(posedge ref_clk) disable iff (!resetn)
    cfg_valid_reg && css_reg[0] == 1'b0 |-> req_src == SRC_PRIM)
    else $error("codes 00 and 10 disagree");
  a_switch_quiet: assert property (@(posedge ref_clk) disable iff (!resetn)
    st_reg != ST_RUN |=> !sys_clk_en)
    else $error("device clock pulsed during switch");
  a_ec_no_wait: assert property (@(posedge ref_clk) disable iff (!resetn)
    is_ec |-> osc_ready)
    else $error("external clock mode waits for start-up");
  a_ec_div_out: assert property (@(posedge ref_clk) disable iff (!resetn)
    is_ec ##1 is_ec |-> !osc_output_pin_oe_n && osc_output_pin_o == $past(div_reg[1]))
    else $error("clock/4 missing on output pin");
  a_hs_feedback: assert property (@(posedge ref_clk) disable iff (!resetn)
    is_hs ##1 is_hs |-> feedback_en && osc_output_pin_oe_n)
    else $error("crystal mode pin or feedback wrong");
  a_pll_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
    pll_active |-> pll_en_reg && (is_ext_pll || is_int_pll))
    else $error("pll running without enable or mode");
  a_int_pll_freq: assert property (@(posedge ref_clk) disable iff (!resetn)
    int_pll_on |-> ifs_reg == IFS_8M || ifs_reg == IFS_4M)
    else $error("internal pll at unsupported frequency");
  a_mode_two_pins: assert property (@(posedge ref_clk) disable iff (!resetn)
    mode_two ##1 mode_two |-> osc_output_pin_oe_n == $past(port_bit_six_dir_n))
    else $error("port bit six not passed to output pin");
  a_req_switch: assert property (@(posedge ref_clk) disable iff (!resetn)
    st_reg == ST_RUN && req_src != cur_src_reg |=> st_reg == ST_OLD ##0 switching)
    else $error("select change did not start a switch");

endmodule : scss_clock_select

// File: design/scss_pkg.sv
// shared constants and types of the system clock source select block
package scss_pkg;

  // ****************************************************************
  // clock source select field encodings
  // ****************************************************************
  localparam logic [1:0] CSS_CONFIG   = 2'h0;  // primary chosen by configuration
  localparam logic [1:0] CSS_TIMER    = 2'h1;  // timer oscillator
  localparam logic [1:0] CSS_PRIMARY  = 2'h2;  // primary oscillator
  localparam logic [1:0] CSS_INTERNAL = 2'h3;  // internal oscillator block
  localparam logic [1:0] CSS_RESET    = CSS_CONFIG;

  // ****************************************************************
  // internal frequency select encodings
  // ****************************************************************
  localparam logic [2:0] IFS_8M    = 3'h7;  // fast rc direct
  localparam logic [2:0] IFS_4M    = 3'h6;
  localparam logic [2:0] IFS_31K   = 3'h0;  // fast rc / 256 or slow rc
  localparam logic [2:0] IFS_RESET = IFS_4M;

  // ****************************************************************
  // oscillator configuration encodings
  // ****************************************************************
  localparam logic [2:0] CFG_EXT_CLK_PLL = 3'h7;
  localparam logic [2:0] CFG_EXT_CLK     = 3'h6;
  localparam logic [2:0] CFG_CRYSTAL_PLL = 3'h5;
  localparam logic [2:0] CFG_CRYSTAL     = 3'h4;
  localparam logic [2:0] CFG_INT_PLL_ONE = 3'h3;
  localparam logic [2:0] CFG_INT_PLL_TWO = 3'h2;
  localparam logic [2:0] CFG_INT_IO_ONE  = 3'h1;
  localparam logic [2:0] CFG_INT_IO_TWO  = 3'h0;

  // ****************************************************************
  // timing and sizing
  // ****************************************************************
  localparam logic [1:0] OLD_TICKS   = 2'h2;     // old-source cycles before pause
  localparam logic [1:0] NEW_TICKS   = 2'h3;     // new-source cycles before run
  localparam logic [3:0] LF_SHIFT    = 4'h8;     // fast rc / 256 for 31 kHz
  localparam int         PLL_SHIFT   = 2;        // times four
  localparam int         PER_W       = 16;       // period counter width
  localparam logic [9:0] OST_TICKS   = 10'h3ff;  // crystal start-up count, minus one
  localparam int         N_SYNC      = 5;
  localparam int         SY_OSC_IN   = 0;
  localparam int         SY_FAST     = 1;
  localparam int         SY_SLOW     = 2;
  localparam int         SY_TIMER    = 3;
  localparam int         SY_OSC_OUT  = 4;

  typedef enum logic [1:0] {SRC_SLOW, SRC_PRIM, SRC_TIMER, SRC_INTB} scss_src_t;
  typedef enum logic [1:0] {ST_RUN, ST_OLD, ST_NEW} scss_sw_state_t;

endpackage : scss_pkg

// File: verif/scss_ext_clk_src.sv
// external clock source model for the oscillator input pin
module scss_ext_clk_src #(
  parameter int HALF_NS = 50  // half period, 10 MHz default
) (
  input  wire logic run,      // source running
  output logic      pin       // level onto the input pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // free-running; a stopped source shows no edges, so nothing gets counted
  initial pin = 1'b0;
  always #(HALF_NS) pin = run ? ~pin : 1'b0;
endmodule : scss_ext_clk_src

// File: verif/system_clock_source_select_tb_top.sv
// self-checking bench for the system clock source select block
module system_clock_source_select_tb_top;
  import scss_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic       ref_clk = 0, resetn = 0, ext_run = 1, fast = 0, slow = 0, tmr = 0, ext_pin;
  logic       cfg_ld = 0, wr = 0, pll_w = 0, lfs_w = 0, p7 = 0, p7d = 1, p6 = 0, p6d = 1;
  logic [3:0] feat = 0;
  logic [2:0] cfg = 0, ifs_w = 3'h6, ifs;
  logic [1:0] css_w = 0, css, asrc;
  logic       pll, lfs, sw, rdy, plla, fen, sen, fb, i_o, i_oe, o_o, o_oe, p7i, p6i, clk_en;
  int         n_fail = 0, n_compared = 0;
  // ****************************************************************
  // clocks, pins and design
  // ****************************************************************
  always #5 ref_clk = ~ref_clk;
  always #62.5 fast = ~fast;
  always #1000 slow = ~slow;  // slow rc sped up to keep the run short
  always #1500 tmr = ~tmr;
  scss_ext_clk_src src (.run(ext_run), .pin(ext_pin));
  scss_clock_select dut (.ref_clk(ref_clk), .resetn(resetn),
    .osc_input_pin_i(!i_oe ? i_o : ext_pin), .osc_input_pin_o(i_o), .osc_input_pin_oe_n(i_oe),
    .osc_output_pin_i(!o_oe ? o_o : ~o_o), .osc_output_pin_o(o_o), .osc_output_pin_oe_n(o_oe),
    .fast_rc_osc(fast), .slow_rc_osc(slow), .timer_osc(tmr), .config_loaded(cfg_ld),
    .osc_config(cfg), .ctrl_wr(wr), .clock_source_select_wr(css_w),
    .internal_freq_select_wr(ifs_w), .pll_enable_bit_wr(pll_w),
    .low_freq_source_select_wr(lfs_w), .pwrt_en(feat[0]), .fscm_en(feat[1]), .wdt_en(feat[2]),
    .two_speed_en(feat[3]), .port_bit_seven_out(p7), .port_bit_seven_dir_n(p7d),
    .port_bit_six_out(p6), .port_bit_six_dir_n(p6d), .port_bit_seven_in(p7i),
    .port_bit_six_in(p6i), .clock_source_select(css), .internal_freq_select(ifs),
    .pll_enable_bit(pll), .low_freq_source_select(lfs), .sys_clk_en(clk_en), .active_src(asrc),
    .switching(sw), .osc_ready(rdy), .pll_active(plla), .fast_rc_en(fen), .slow_rc_en(sen),
    .feedback_en(fb));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task summarize;
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // reset, check reset state, then load the configuration
  task boot(input logic [2:0] c);
    resetn = 0;
    cfg_ld = 0;
    cfg = c;
    repeat (3) @(negedge ref_clk);
    chk(8'({css, ifs, pll, lfs}), 8'({CSS_RESET, IFS_RESET, 2'h0}));
    chk(8'({sen, i_oe, o_oe, asrc}), 8'h1c);
    resetn = 1;
    @(negedge ref_clk);
    cfg_ld = 1;
  endtask : boot
  task wrc(input logic [1:0] s, input logic [2:0] f, input logic p);
    css_w = s;
    ifs_w = f;
    pll_w = p;
    wr = 1;
    @(negedge ref_clk);
    wr = 0;
    @(negedge ref_clk);
  endtask : wrc
  // wait up to 20 cycles for a switch; it must end with the device clock kept paused
  task swt;
    int i, bad;
    bad = 0;
    for (i = 0; i < 20 && sw !== 1'b1; i++) @(negedge ref_clk);
    for (i = 0; i < 5000 && sw !== 1'b0; i++) begin
      @(negedge ref_clk);
      bad += int'(clk_en === 1'b1 && sw === 1'b1);
    end
    chk(8'({sw, bad != 0}), 8'h0);
  endtask : swt
  // device clock pulses in 500 cycles, lets any pll settle first
  task rate(input int lo, input int hi);
    int n;
    n = 0;
    repeat (50) @(negedge ref_clk);
    repeat (500) begin
      @(negedge ref_clk);
      n += int'(clk_en === 1'b1);
    end
    chk(8'(n >= lo && n <= hi), 8'h1);
  endtask : rate
  initial begin
    int   tg;
    logic prv;
    boot(CFG_EXT_CLK);
    swt();
    chk(8'({asrc, rdy, fb, o_oe}), 8'h0c);
    tg = 0;
    prv = o_o;
    repeat (200) begin
      @(negedge ref_clk);
      tg += int'(o_o !== prv);
      prv = o_o;
    end
    chk(8'(tg >= 8 && tg <= 12), 8'h1);
    wrc(CSS_PRIMARY, IFS_4M, 1);
    chk(8'({sw, plla}), 8'h0);
    wrc(CSS_INTERNAL, IFS_4M, 0);
    swt();
    chk(8'({asrc, fen}), 8'h7);
    feat = 4'h4;
    repeat (2) @(negedge ref_clk);
    chk(8'(sen), 8'h1);
    boot(CFG_EXT_CLK_PLL);
    swt();
    wrc(CSS_CONFIG, IFS_4M, 1);
    chk(8'(plla), 8'h1);
    rate(190, 210);
    wrc(CSS_CONFIG, IFS_4M, 0);
    chk(8'(plla), 8'h0);
    boot(CFG_INT_PLL_ONE);
    swt();
    p7d = 0;
    p7 = 1;
    wrc(CSS_CONFIG, IFS_8M, 1);
    chk(8'({plla, i_oe, i_o, o_oe}), 8'h0a);
    rate(150, 170);
    wrc(CSS_CONFIG, 3'h5, 1);
    chk(8'(plla), 8'h0);
    boot(CFG_INT_IO_TWO);
    swt();
    p6d = 0;
    p6 = 1;
    repeat (3) @(negedge ref_clk);
    chk(8'({o_oe, o_o}), 8'h1);
    rate(18, 22);
    summarize();
  end
  initial begin
    #1ms;
    n_fail++;
    summarize();
  end
endmodule : system_clock_source_select_tb_top
